// *** rtl/sap_defs.svh ***
// Offsets, field positions, reset values and timing counts of the profile block
`ifndef SAP_DEFS_SVH
`define SAP_DEFS_SVH

`define SAP_WORD_BITS 16
`define SAP_ADDR_MSB 15
`define SAP_ADDR_LSB 12
`define SAP_SUB_BIT 11

`define SAP_ADDR_CTRL 4'h8
`define SAP_ADDR_PARAM 4'h9
`define SAP_ADDR_CYCLE 4'ha
`define SAP_ADDR_COUNT 4'hb

`define SAP_PM_LSB 0
`define SAP_DIV_LSB 2
`define SAP_TBL_LSB 5
`define SAP_STM_LSB 7
`define SAP_DEC_BIT 9
`define SAP_ACC_BIT 10

`define SAP_CUR_LSB 0
`define SAP_MODE0_BIT 8
`define SAP_MODE1_BIT 9
`define SAP_CC_BIT 10

`define SAP_CTRL_RST 11'h000
`define SAP_PARAM_RST 11'h000
`define SAP_CYCLE_RST 12'h000
`define SAP_COUNT_RST 12'h000

`define SAP_RAMP_PULSES 94
`define SAP_LAST_STEP 4'hf
`define SAP_UNIT_NS 2000
`define SAP_CLK_NS 100
`define SAP_UNIT_CYC (`SAP_UNIT_NS / `SAP_CLK_NS)

`endif

// *** rtl/sap_pkg.sv ***
// Types shared by the stepper speed-profile block
package sap_pkg;

   typedef enum logic [1:0] {
      SAP_IDLE = 2'b00,
      SAP_ACCEL = 2'b01,
      SAP_CRUISE = 2'b10,
      SAP_DECEL = 2'b11
   } sap_run_t;

   typedef enum logic [1:0] {
      SAP_TBL_ABRUPT = 2'b00,
      SAP_TBL_ABRUPT_ALT = 2'b01,
      SAP_TBL_GENTLE = 2'b10,
      SAP_TBL_LINEAR = 2'b11
   } sap_table_t;

   typedef struct packed {
      logic sclk_prev;
      logic latch_prev;
      logic [15:0] shreg;
      logic [4:0] cnt;
      logic [15:0] word;
      logic valid;
   } sap_rx_t;

   typedef struct packed {
      logic [10:0] ctrl;
      logic [10:0] param;
      logic [11:0] cycle;
      logic [11:0] count;
      sap_run_t state;
      logic [13:0] total;
      logic [13:0] emitted;
      logic [3:0] step;
      logic [6:0] spc;
      logic [4:0] pre;
      logic [19:0] units;
      logic pulse;
      logic [5:0] pos;
      logic full_duty;
      logic cc_hold;
   } sap_core_t;

endpackage

// *** rtl/sap_serial_rx.sv ***
// Serial control word receiver framed by the latch input
`timescale 1ns/10ps
`default_nettype none
`include "sap_defs.svh"

module sap_serial_rx
   import sap_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_ser_clk,
   input wire logic i_ser_data,
   input wire logic i_latch,
   output logic [15:0] o_word,
   output logic o_word_valid
);

   sap_rx_t q;
   sap_rx_t d;

   // ****************************************
   // Shift and latch
   // ****************************************
   always_comb begin
      d = q;
      d.valid = 1'b0;
      d.sclk_prev = i_ser_clk;
      d.latch_prev = i_latch;
      if (i_latch && !q.latch_prev) begin
         d.cnt = 5'h00;
      end else if (i_latch && i_ser_clk && !q.sclk_prev) begin
         d.shreg = {q.shreg[14:0], i_ser_data};
         // Saturate so an overlong frame is rejected, not wrapped
         if (q.cnt != 5'h11) begin
            d.cnt = q.cnt + 5'h01;
         end
      end else if (!i_latch && q.latch_prev) begin
         if (q.cnt == 5'(`SAP_WORD_BITS)) begin
            d.word = q.shreg;
            d.valid = 1'b1;
         end
         d.cnt = 5'h00;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_word = q.word;
   assign o_word_valid = q.valid;

endmodule
`default_nettype wire

// *** rtl/sap_step_table.sv ***
// Increment weights and per-step pulse counts of the ramp tables
`timescale 1ns/10ps
`default_nettype none

module sap_step_table
   import sap_pkg::*;
(
   input wire logic [3:0] i_step,
   input wire logic [1:0] i_table,
   output logic [7:0] o_weight,
   output logic [4:0] o_count
);

   // Index 0 is the plain base cycle outside any ramp
   localparam logic [7:0] WEIGHT [0:15] = '{8'h00, 8'h78, 8'h38, 8'h23, 8'h18, 8'h12,
      8'h0d, 8'h0a, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
   localparam logic [4:0] ABRUPT [0:15] = '{5'h00, 5'h02, 5'h05, 5'h02, 5'h01, 5'h01,
      5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h02, 5'h03, 5'h0b, 5'h1f, 5'h1f};
   localparam logic [4:0] GENTLE [0:15] = '{5'h00, 5'h01, 5'h04, 5'h04, 5'h03, 5'h02,
      5'h02, 5'h02, 5'h02, 5'h02, 5'h02, 5'h04, 5'h06, 5'h0c, 5'h11, 5'h1f};
   localparam logic [4:0] LINEAR [0:15] = '{5'h00, 5'h01, 5'h03, 5'h03, 5'h04, 5'h03,
      5'h04, 5'h03, 5'h03, 5'h03, 5'h03, 5'h05, 5'h09, 5'h0d, 5'h0f, 5'h16};

   // ****************************************
   // Lookup
   // ****************************************
   always_comb begin
      o_weight = WEIGHT[i_step];
      case (sap_table_t'(i_table))
         SAP_TBL_GENTLE: begin
            o_count = GENTLE[i_step];
         end
         SAP_TBL_LINEAR: begin
            o_count = LINEAR[i_step];
         end
         default: begin
            o_count = ABRUPT[i_step];
         end
      endcase
   end

endmodule
`default_nettype wire

// *** rtl/sap_stepper_profile.sv ***
// Stepper speed-profile core: control words, ramp sequencer and pulse timer
`timescale 1ns/10ps
`default_nettype none
`include "sap_defs.svh"

module sap_stepper_profile
   import sap_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_ser_clk,
   input wire logic i_ser_data,
   input wire logic i_latch,
   output logic o_step_pulse,
   output logic [5:0] o_step_pos,
   output logic o_busy,
   output logic o_accel,
   output logic o_decel,
   output logic [3:0] o_ramp_step,
   output logic [13:0] o_total_pulses,
   output logic [4:0] o_current_code,
   output logic o_full_duty,
   output logic o_cc_hold
);

   localparam logic [4:0] UNIT_LAST = 5'(`SAP_UNIT_CYC - 1);
   localparam logic [13:0] RAMP_BASE = 14'(`SAP_RAMP_PULSES);

   sap_core_t q;
   sap_core_t d;

   logic [15:0] rx_word;
   logic rx_valid;
   logic [7:0] tbl_weight;
   logic [4:0] tbl_count;

   logic [3:0] word_addr;
   logic word_sub;
   logic [1:0] pm_code;
   logic [2:0] div_code;
   logic [1:0] tbl_code;
   logic [1:0] stm_code;
   logic acc_en;
   logic dec_en;
   logic [1:0] pm_shift;
   logic [2:0] div_shift;
   logic [1:0] stm_shift;
   logic [11:0] ref_inc;
   logic [19:0] inc_prod;
   logic [19:0] period;
   logic [6:0] step_full;
   logic [13:0] ramp_len;
   logic [13:0] start_total;
   logic short_both;
   logic tick;
   logic pulse_ev;
   logic [13:0] e_next;
   logic [13:0] remain;
   logic [3:0] acc_step;
   logic [6:0] acc_spc;
   logic acc_done;
   logic dec_entry;
   logic [6:0] mirror_spc;
   logic wr_ctrl;
   logic wr_param;
   logic wr_cycle;
   logic wr_count;
   sap_run_t start_state;
   logic [3:0] start_step;
   logic [10:0] ctrl_next;
   logic excited;
   logic cc_sel;

   // ****************************************
   // Serial port and tables
   // ****************************************
   sap_serial_rx u_rx (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_ser_clk(i_ser_clk),
      .i_ser_data(i_ser_data),
      .i_latch(i_latch),
      .o_word(rx_word),
      .o_word_valid(rx_valid)
   );

   sap_step_table u_tbl (
      .i_step(q.step),
      .i_table(tbl_code),
      .o_weight(tbl_weight),
      .o_count(tbl_count)
   );

   // ****************************************
   // Field decode
   // ****************************************
   always_comb begin
      word_addr = rx_word[`SAP_ADDR_MSB:`SAP_ADDR_LSB];
      word_sub = rx_word[`SAP_SUB_BIT];
      pm_code = q.param[`SAP_PM_LSB +: 2];
      div_code = q.param[`SAP_DIV_LSB +: 3];
      tbl_code = q.param[`SAP_TBL_LSB +: 2];
      stm_code = q.param[`SAP_STM_LSB +: 2];
      acc_en = q.param[`SAP_ACC_BIT];
      dec_en = q.param[`SAP_DEC_BIT];
      case (pm_code)
         2'b10: pm_shift = 2'd1;
         2'b11: pm_shift = 2'd2;
         default: pm_shift = 2'd0;
      endcase
      // Code 111 is undefined; it is mapped to the largest divisor
      case (div_code)
         3'b011: div_shift = 3'd2;
         3'b100: div_shift = 3'd3;
         3'b101: div_shift = 3'd4;
         3'b110: div_shift = 3'd5;
         3'b111: div_shift = 3'd5;
         default: div_shift = 3'd1;
      endcase
      case (stm_code)
         2'b10: stm_shift = 2'd1;
         2'b11: stm_shift = 2'd2;
         default: stm_shift = 2'd0;
      endcase
   end

   // ****************************************
   // Step period and ramp length
   // ****************************************
   always_comb begin
      // Shift division truncates; small base cycles give a zero increment
      ref_inc = q.cycle >> div_shift;
      inc_prod = {8'h00, ref_inc} * {12'h000, tbl_weight};
      period = {8'h00, q.cycle} + inc_prod;
      step_full = {2'b00, tbl_count} << stm_shift;
      ramp_len = RAMP_BASE << stm_shift;
      start_total = {2'b00, rx_word[11:0]} << pm_shift;
      short_both = acc_en && dec_en && (q.total < (ramp_len << 1));
   end

   // ****************************************
   // Pulse timer
   // ****************************************
   always_comb begin
      tick = (q.pre == UNIT_LAST);
      pulse_ev = (q.state != SAP_IDLE) && (q.cycle != 12'h000) && tick
         && (q.units >= (period - 20'h00001));
      e_next = q.emitted + 14'h0001;
      remain = q.total - e_next;
      acc_done = (q.spc + 7'h01) == step_full;
      acc_step = acc_done ? q.step + 4'h1 : q.step;
      acc_spc = acc_done ? 7'h00 : q.spc + 7'h01;
      // Mirror: undo the pulses already spent in this step
      mirror_spc = acc_done ? 7'h00 : step_full - acc_spc;
      // Odd short moves turn at the rounded-up half, so decel ends by step one
      dec_entry = dec_en && (short_both ? (e_next == ((q.total + 14'h0001) >> 1))
         : (remain <= ramp_len));
   end

   // ****************************************
   // Write strobes
   // ****************************************
   // A strobe needs a whole accepted frame, so a cut frame never lands
   always_comb begin
      wr_ctrl = 1'b0;
      wr_param = 1'b0;
      wr_cycle = 1'b0;
      wr_count = 1'b0;
      if (rx_valid) begin
         if ((word_addr == `SAP_ADDR_CTRL) && !word_sub) begin
            wr_ctrl = 1'b1;
         end else if ((word_addr == `SAP_ADDR_PARAM) && !word_sub) begin
            wr_param = 1'b1;
         end else if (word_addr == `SAP_ADDR_CYCLE) begin
            wr_cycle = 1'b1;
         end else if (word_addr == `SAP_ADDR_COUNT) begin
            wr_count = 1'b1;
         end
      end
   end

   // ****************************************
   // Move start
   // ****************************************
   always_comb begin
      if (start_total == 14'h0000) begin
         start_state = SAP_IDLE;
         start_step = 4'h0;
      end else if (acc_en) begin
         start_state = SAP_ACCEL;
         start_step = 4'h1;
      end else if (dec_en && (start_total <= ramp_len)) begin
         start_state = SAP_DECEL;
         start_step = `SAP_LAST_STEP;
      end else begin
         start_state = SAP_CRUISE;
         start_step = 4'h0;
      end
   end

   // ****************************************
   // Drive mode
   // ****************************************
   // Micro-step mode ignores the current select bit
   always_comb begin
      ctrl_next = wr_ctrl ? rx_word[10:0] : q.ctrl;
      excited = ctrl_next[`SAP_MODE0_BIT];
      cc_sel = ctrl_next[`SAP_CC_BIT];
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      d = q;
      d.pulse = 1'b0;
      if (wr_ctrl) begin
         d.ctrl = rx_word[10:0];
      end
      if (wr_param) begin
         d.param = rx_word[10:0];
      end
      if (wr_cycle) begin
         d.cycle = rx_word[11:0];
      end
      if (wr_count) begin
         d.count = rx_word[11:0];
      end

      // Timer holds while the base cycle is zero, keeping position
      if ((q.state != SAP_IDLE) && (q.cycle != 12'h000)) begin
         d.pre = tick ? 5'h00 : q.pre + 5'h01;
         if (tick) begin
            d.units = pulse_ev ? 20'h00000 : q.units + 20'h00001;
         end
      end

      if (pulse_ev) begin
         d.pulse = 1'b1;
         d.pos = q.pos + 6'h01;
         d.emitted = e_next;
         case (q.state)
            SAP_ACCEL: begin
               d.step = acc_step;
               d.spc = acc_spc;
               if (acc_done && (q.step == `SAP_LAST_STEP)) begin
                  d.state = SAP_CRUISE;
                  d.step = 4'h0;
               end
               if (dec_entry) begin
                  d.state = SAP_DECEL;
                  d.step = q.step;
                  d.spc = mirror_spc;
               end
            end
            SAP_CRUISE: begin
               if (dec_en && (remain <= ramp_len)) begin
                  d.state = SAP_DECEL;
                  d.step = `SAP_LAST_STEP;
                  d.spc = 7'h00;
               end
            end
            SAP_DECEL: begin
               if (q.step != 4'h0) begin
                  if ((q.spc + 7'h01) == step_full) begin
                     d.step = q.step - 4'h1;
                     d.spc = 7'h00;
                  end else begin
                     d.spc = q.spc + 7'h01;
                  end
               end
            end
            default: begin
               d.state = SAP_IDLE;
            end
         endcase
         if (e_next == q.total) begin
            d.state = SAP_IDLE;
            d.step = 4'h0;
            d.spc = 7'h00;
         end
      end

      // A fresh count word restarts the move with the current parameters
      if (wr_count) begin
         d.total = start_total;
         d.emitted = 14'h0000;
         d.pre = 5'h00;
         d.units = 20'h00000;
         d.spc = 7'h00;
         d.state = start_state;
         d.step = start_step;
      end

      d.full_duty = excited && !cc_sel;
      d.cc_hold = excited && cc_sel;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign o_step_pulse = q.pulse;
   assign o_step_pos = q.pos;
   assign o_busy = (q.state != SAP_IDLE);
   assign o_accel = (q.state == SAP_ACCEL);
   assign o_decel = (q.state == SAP_DECEL);
   assign o_ramp_step = q.step;
   assign o_total_pulses = q.total;
   assign o_current_code = q.ctrl[`SAP_CUR_LSB +: 5];
   assign o_full_duty = q.full_duty;
   assign o_cc_hold = q.cc_hold;

endmodule
`default_nettype wire

// *** sim/sap_host_model.sv ***
// Host model that frames and shifts serial control words
`timescale 1ns/10ps
`default_nettype none
module sap_host_model (
   input wire logic i_sys_clk,
   output logic o_ser_clk,
   output logic o_ser_data,
   output logic o_latch
);
   initial begin
      o_ser_clk = 1'b0;
      o_ser_data = 1'b0;
      o_latch = 1'b0;
   end
   // Frames shorter than 16 bits are only sent to be refused
   task automatic send(input logic [15:0] w, input int nbits);
      @(posedge i_sys_clk);
      o_latch <= 1'b1;
      @(posedge i_sys_clk);
      for (int i = 15; i > 15 - nbits; i--) begin
         o_ser_clk <= 1'b0;
         o_ser_data <= w[i];
         @(posedge i_sys_clk);
         o_ser_clk <= 1'b1;
         @(posedge i_sys_clk);
      end
      // Released line shows the inverse, never a stale copy
      o_ser_clk <= 1'b0;
      o_latch <= 1'b0;
      o_ser_data <= ~o_ser_data;
      repeat (5) @(posedge i_sys_clk);
   endtask
endmodule
`default_nettype wire

// *** sim/sap_stepper_profile_asserts.sv ***
// Port checks for the stepper speed-profile block
`timescale 1ns/10ps
`default_nettype none
module sap_stepper_profile_asserts (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_latch,
   input wire logic o_step_pulse,
   input wire logic [5:0] o_step_pos,
   input wire logic o_busy,
   input wire logic o_accel,
   input wire logic o_decel,
   input wire logic [3:0] o_ramp_step,
   input wire logic [13:0] o_total_pulses,
   input wire logic [4:0] o_current_code,
   input wire logic o_full_duty,
   input wire logic o_cc_hold
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_nrst);
   // Shortest period is 20 cycles, so 8 quiet cycles is safe
   sequence s_quiet;
      (!o_step_pulse) [*8];
   endsequence
   sequence s_after_frame;
      !i_latch && ($past(i_latch, 2) || $past(i_latch, 3) || $past(i_latch, 4));
   endsequence
   pulse_gap_a: assert property (o_step_pulse |=> s_quiet)
      else $error("pulse gap");
   pos_step_a: assert property ($changed(o_step_pos) |->
      o_step_pos == 6'($past(o_step_pos) + 6'h01) && (o_step_pulse || $past(o_step_pulse)))
      else $error("step position");
   pulse_busy_a: assert property (o_step_pulse |-> o_busy || $past(o_busy))
      else $error("pulse while idle");
   busy_count_a: assert property ($rose(o_busy) |-> o_total_pulses != 14'h0000)
      else $error("busy without count");
   ramp_flags_a: assert property ((o_accel || o_decel) |->
      o_busy && !(o_accel && o_decel) && o_ramp_step != 4'h0)
      else $error("ramp flags");
   accel_walk_a: assert property (o_accel && $past(o_accel) && $changed(o_ramp_step) |->
      o_ramp_step == $past(o_ramp_step) + 4'h1 || o_ramp_step == 4'h1)
      else $error("accel step order");
   decel_walk_a: assert property (o_decel && $past(o_decel) && $changed(o_ramp_step) |->
      o_ramp_step == $past(o_ramp_step) - 4'h1 || o_ramp_step == 4'hf)
      else $error("decel step order");
   duty_mode_a: assert property (o_full_duty |-> !o_cc_hold)
      else $error("duty modes");
   word_latch_a: assert property ($changed(o_total_pulses) || $changed(o_current_code) |->
      s_after_frame)
      else $error("field change outside frame");
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the stepper speed-profile block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic i_sys_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_ser_clk, i_ser_data, i_latch, o_step_pulse, o_busy, o_accel, o_decel;
   logic o_full_duty, o_cc_hold;
   logic [5:0] o_step_pos;
   logic [3:0] o_ramp_step;
   logic [13:0] o_total_pulses;
   logic [4:0] o_current_code;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int acc [16];
   int dec [16];
   int tcnt [3][15] = '{'{2, 5, 2, 1, 1, 1, 1, 1, 1, 1, 2, 3, 11, 31, 31},
      '{1, 4, 4, 3, 2, 2, 2, 2, 2, 2, 4, 6, 12, 17, 31},
      '{1, 3, 3, 4, 3, 4, 3, 3, 3, 3, 5, 9, 13, 15, 22}};

   always #50 i_sys_clk = ~i_sys_clk;

   sap_stepper_profile DUT (.*);
   sap_host_model host (
      .i_sys_clk(i_sys_clk),
      .o_ser_clk(i_ser_clk),
      .o_ser_data(i_ser_data),
      .o_latch(i_latch)
   );

   task automatic close_out();
      if (err_total == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         err_total++;
         close_out();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      host.send({a, d}, 16);
   endtask

   task automatic par(input logic [10:0] p);
      wr(4'h9, {1'b0, p});
   endtask

   task automatic gap(output int g, input int lim = 80000);
      g = 0;
      do begin
         @(posedge i_sys_clk);
         #1;
         g++;
      end while (o_step_pulse !== 1'b1 && g < lim);
   endtask

   // Pulse is charged to the ramp state of the cycle before it
   task automatic run(output int n);
      logic pa, pd;
      logic [3:0] ps;
      n = 0;
      pa = 1'b0;
      pd = 1'b0;
      ps = 4'h0;
      acc = '{default: 0};
      dec = '{default: 0};
      for (int k = 0; k < 20000 && o_busy === 1'b1; k++) begin
         @(posedge i_sys_clk);
         #1;
         if (o_step_pulse === 1'b1) begin
            n++;
            acc[ps] += pa;
            dec[ps] += pd;
         end
         pa = o_accel;
         pd = o_decel;
         ps = o_ramp_step;
      end
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      int n;
      chk("busy", 16'h0000, 16'(o_busy));
      chk("total", 16'h0000, 16'(o_total_pulses));
      wr(4'ha, 12'h001);
      wr(4'hb, 12'h00a);
      run(n);
      chk("pulses", 16'h000a, 16'(n));
      chk("ramps", 16'h0000, 16'(acc[1] + dec[15]));
      chk("position", 16'h000a, 16'(o_step_pos));
   endtask

   task automatic t_mult();
      for (int c = 0; c < 4; c++) begin
         par({9'h000, 2'(c)});
         wr(4'hb, 12'h005);
         chk("total", 16'(5 << ((c > 1) ? c - 1 : 0)), 16'(o_total_pulses));
      end
      host.send(16'h9800, 16);
      wr(4'hb, 12'h005);
      chk("sub bit", 16'h0014, 16'(o_total_pulses));
      host.send(16'h9000, 15);
      wr(4'hb, 12'h005);
      chk("short frame", 16'h0014, 16'(o_total_pulses));
      wr(4'hb, 12'h000);
   endtask

   task automatic t_ctrl();
      logic [2:0] m;
      for (int c = 0; c < 8; c++) begin
         m = 3'(c);
         wr(4'h8, {1'b0, m, 3'b100, 5'h13});
         chk("full duty", 16'(m[0] & ~m[2]), 16'(o_full_duty));
         chk("hold", 16'(m[0] & m[2]), 16'(o_cc_hold));
      end
      host.send(16'h8807, 16);
      chk("current", 16'h0013, 16'(o_current_code));
   endtask

   task automatic t_cycle0();
      int g;
      wr(4'ha, 12'h000);
      wr(4'hb, 12'h005);
      gap(g, 200);
      chk("frozen", 16'h00c8, 16'(g));
      chk("busy", 16'h0001, 16'(o_busy));
      wr(4'hb, 12'h000);
      chk("stopped", 16'h0000, 16'(o_busy));
   endtask

   task automatic t_ramp(input logic [1:0] tb, st, input logic a, d, input logic [11:0] cnt);
      int n;
      int m;
      int r;
      m = (st == 2'b11) ? 4 : (st == 2'b10) ? 2 : 1;
      r = (tb == 2'b11) ? 2 : (tb == 2'b10) ? 1 : 0;
      par({a, d, st, tb, 3'b100, 2'b00});
      wr(4'ha, 12'h001);
      wr(4'hb, cnt);
      run(n);
      chk("pulses", 16'(cnt), 16'(n));
      for (int s = 1; s < 16; s++) begin
         chk("accel", a ? 16'(tcnt[r][s - 1] * m) : 16'h0000, 16'(acc[s]));
         chk("decel", d ? 16'(tcnt[r][s - 1] * m) : 16'h0000, 16'(dec[s]));
      end
   endtask

   task automatic t_short();
      int n;
      par({4'b1100, 2'b00, 3'b100, 2'b00});
      wr(4'hb, 12'h064);
      run(n);
      chk("short accel", 16'h0032, 16'(acc.sum()));
      chk("short decel", 16'h0032, 16'(dec.sum()));
      wr(4'hb, 12'h065);
      run(n);
      chk("odd accel", 16'h0033, 16'(acc.sum()));
      chk("odd decel", 16'h0032, 16'(dec.sum()));
   endtask

   task automatic t_weights();
      int g;
      par({4'b1000, 2'b00, 3'b011, 2'b00});
      wr(4'ha, 12'h008);
      wr(4'hb, 12'h0c8);
      gap(g);
      gap(g);
      chk("step one", 16'h1360, 16'(g));
      gap(g);
      chk("step two", 16'h0960, 16'(g));
      wr(4'hb, 12'h000);
   endtask

   task automatic t_div();
      int g;
      int sh;
      for (int c = 0; c < 7; c++) begin
         sh = (c < 3) ? 1 : c - 1;
         par({4'b0100, 2'b00, 3'(c), 2'b00});
         wr(4'ha, 12'h020);
         wr(4'hb, 12'h028);
         gap(g);
         gap(g);
         chk("divisor", 16'((32 + (32 >> sh)) * 20), 16'(g));
         wr(4'hb, 12'h000);
      end
   endtask

   initial begin
      repeat (16) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      @(posedge i_sys_clk);
      t_reset();
      t_mult();
      t_ctrl();
      t_cycle0();
      for (int t = 0; t < 4; t++) begin
         t_ramp(2'(t), 2'b00, 1'b1, 1'b1, 12'h0bc);
      end
      t_ramp(2'b00, 2'b01, 1'b1, 1'b1, 12'h0bc);
      t_ramp(2'b00, 2'b10, 1'b1, 1'b1, 12'h178);
      t_ramp(2'b00, 2'b11, 1'b1, 1'b1, 12'h2f0);
      t_ramp(2'b00, 2'b00, 1'b1, 1'b0, 12'h0bc);
      t_ramp(2'b00, 2'b00, 1'b0, 1'b1, 12'h0bc);
      t_ramp(2'b00, 2'b00, 1'b0, 1'b0, 12'h0bc);
      t_short();
      t_weights();
      t_div();
      close_out();
   end
endmodule

bind sap_stepper_profile sap_stepper_profile_asserts u_chk (.*);
`default_nettype wire
